// File: hdl/sbs_mem.sv
// lane-writable word memory with registered read data
`timescale 1ns/1ps
module sbs_mem #(
    parameter int ADDR_W = sbs_pkg::ADDR_W,
    parameter int LANES  = sbs_pkg::LANES,
    parameter int LANE_W = sbs_pkg::LANE_W
) (
    input  logic                    core_clk,
    input  logic                    nrst,
    input  logic [LANES-1:0]        wr_lanes,
    input  logic [ADDR_W-1:0]       wr_addr,
    input  logic [LANES*LANE_W-1:0] wr_data,
    input  logic [ADDR_W-1:0]       rd_addr,
    output logic [LANES*LANE_W-1:0] rd_data
);

    logic [LANES*LANE_W-1:0] mem [0:(2**ADDR_W)-1];
    logic [LANES*LANE_W-1:0] next_rd_data;

    // ************************************************************************
    // read path
    // ************************************************************************
    // write-first: a lane written at this edge is seen by the read
    always_comb begin
        next_rd_data = mem[rd_addr];
        for (int i = 0; i < LANES; i++) begin
            if (wr_lanes[i] && (wr_addr == rd_addr)) begin
                next_rd_data[i*LANE_W +: LANE_W] = wr_data[i*LANE_W +: LANE_W];
            end
        end
    end

    // registered read data and lane writes
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rd_data <= '0;
        end else begin
            rd_data <= next_rd_data;
        end
        for (int i = 0; i < LANES; i++) begin
            if (wr_lanes[i]) begin
                mem[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
            end
        end
    end

endmodule // sbs_mem

// File: hdl/sbs_pkg.sv
// constants, types and helper functions for the synchronous burst sram port
// ****************************************************************************
// Summary of operation
// - processor strobe captures address, loads counter
// - controller strobe captures address, loads counter
// - both strobes low: processor strobe wins
// - processor strobe ignored when first select high
// - byte write needs enable low, selects pick lanes
// - all-bytes write low writes every lane
// - writes finish internally, self-timed
// - sleep input idles device, keeps contents
// - input data captured on rising edge
// - output enable low drives, high floats
// - float on write, emerging, and deselect
// - parity lanes follow data, gated per lane
// - strap: low linear, high interleaved, static
// - scan output changes on test clock fall
// - scan inputs sampled on test clock rise
// - inputs registered; read data flows through
// - two-bit wraparound burst counter
// - read starts: all selects active, strobe low
// - selected only with first low, second high, third low
// - advance low increments burst counter
// - selects sampled only on new address load
// - linear adds one; interleaved xors step
// ****************************************************************************
package sbs_pkg;

    // ************************************************************************
    // sizes
    // ************************************************************************
    localparam int ADDR_W    = 20;      // word address width of the array
    localparam int LANES     = 4;       // byte lanes per word
    localparam int LANE_DQ_W = 8;       // data bits per lane
    localparam int LANE_W    = 9;       // data plus parity bit per lane
    localparam int DQ_W      = 32;      // data bus width
    localparam int WORD_W    = 36;      // stored word width
    localparam int BURST_W   = 2;       // burst counter width

    // ************************************************************************
    // timing
    // ************************************************************************
    localparam int CLK_PERIOD_PS    = 8000;   // core_clk period
    localparam int ACCESS_DELAY_PS  = 6500;   // longest clock-to-data time
    localparam int ACCESS_DELAY_CYC = (ACCESS_DELAY_PS / CLK_PERIOD_PS < 1) ? 1 :
                                      ACCESS_DELAY_PS / CLK_PERIOD_PS;
    localparam logic [2:0] TAP_RESET_TMS_COUNT = 3'h5;  // tms-high rises to reset scan

    // ************************************************************************
    // encodings and reset values
    // ************************************************************************
    localparam logic       MODE_LINEAR      = 1'b0;
    localparam logic       MODE_INTERLEAVED = 1'b1;
    localparam logic [3:0] ALL_LANES        = 4'hf;
    localparam logic [3:0] NO_LANES         = 4'h0;
    localparam logic [1:0] BURST_STEP_ZERO  = 2'h0;
    localparam logic [1:0] BURST_STEP_ONE   = 2'h1;
    localparam logic [35:0] WORD_ZERO       = 36'h0;

    typedef enum logic [1:0] {
        SBS_DESEL = 2'b00,
        SBS_READ  = 2'b01,
        SBS_WRITE = 2'b10,
        SBS_SLEEP = 2'b11
    } sbs_state_e;

    // data bus as seen at the pins
    typedef struct packed {
        logic [3:0]  par;
        logic [31:0] dq;
    } sbs_bus_s;

    // write waiting for the self-timed array write
    typedef struct packed {
        logic [3:0]  lanes;
        logic [35:0] data;
    } sbs_wr_s;

    // ************************************************************************
    // functions
    // ************************************************************************
    // low address bits for a burst step
    function automatic logic [1:0] burst_low(input logic [1:0] base,
                                             input logic [1:0] step,
                                             input logic       mode);
        burst_low = (mode == MODE_INTERLEAVED) ? (base ^ step) : 2'(base + step);
    endfunction

    // pins to stored word: lane i holds parity i above data byte i
    function automatic logic [35:0] to_lanes(input sbs_bus_s bus);
        logic [35:0] w;
        w = WORD_ZERO;
        for (int i = 0; i < LANES; i++) begin
            w[i*LANE_W +: LANE_W] = {bus.par[i], bus.dq[i*LANE_DQ_W +: LANE_DQ_W]};
        end
        to_lanes = w;
    endfunction

    // stored word back to pins
    function automatic sbs_bus_s from_lanes(input logic [35:0] w);
        sbs_bus_s b;
        b = '0;
        for (int i = 0; i < LANES; i++) begin
            b.par[i]                        = w[i*LANE_W + LANE_DQ_W];
            b.dq[i*LANE_DQ_W +: LANE_DQ_W]  = w[i*LANE_W +: LANE_DQ_W];
        end
        from_lanes = b;
    endfunction

endpackage

// File: hdl/sbs_port.sv
// synchronous flow-through burst sram port with common data bus
`timescale 1ns/1ps
module sbs_port #(
    parameter int ADDR_W = sbs_pkg::ADDR_W
) (
    input  logic              core_clk,
    input  logic              nrst,
    input  logic [ADDR_W-1:0] addr,
    input  logic              proc_addr_strobe_n,
    input  logic              ctrl_addr_strobe_n,
    input  logic              burst_advance_n,
    input  logic              chip_sel_first_n,
    input  logic              chip_sel_second,
    input  logic              chip_sel_third_n,
    input  logic              byte_wr_enable_n,
    input  logic [3:0]        byte_lane_select_n,
    input  logic              all_bytes_write_n,
    input  logic              out_enable_n,
    input  logic              sleep_request,
    input  logic              burst_order_mode,
    input  logic [31:0]       dq_in,
    input  logic [3:0]        parity_lanes_in,
    input  logic              tck,
    input  logic              tms,
    input  logic              tdi,
    output logic [31:0]       dq_out,
    output logic [3:0]        parity_lanes_out,
    output logic              dq_oe_n,
    output logic              sleep_active,
    output logic              tdo
);

    // ************************************************************************
    // declarations
    // ************************************************************************
    sbs_pkg::sbs_state_e      state;
    sbs_pkg::sbs_state_e      next_state;
    logic [ADDR_W-1:2]        addr_hi;
    logic [ADDR_W-1:2]        next_addr_hi;
    logic [1:0]               burst_base;
    logic [1:0]               next_burst_base;
    logic [1:0]               burst_step;
    logic [1:0]               next_burst_step;
    logic                     emerge;
    logic                     next_emerge;
    sbs_pkg::sbs_wr_s         wr_pend;
    sbs_pkg::sbs_wr_s         next_wr_pend;
    logic [ADDR_W-1:0]        wr_addr;
    logic [ADDR_W-1:0]        next_wr_addr;
    logic                     next_dq_oe_n;
    logic                     next_sleep_active;
    logic                     mode;
    logic                     next_mode;
    logic                     sleep_meta;
    logic                     sleep_sync;
    logic                     tck_q;
    logic                     next_tck_q;
    logic                     scan_bit;
    logic                     next_scan_bit;
    logic [2:0]               tms_count;
    logic [2:0]               next_tms_count;
    logic                     next_tdo;
    logic                     proc_take;
    logic                     ctrl_take;
    logic                     load;
    logic                     cs_active;
    logic [3:0]               wr_lanes_req;
    logic [ADDR_W-1:0]        rd_addr;
    logic [35:0]              rd_word;
    sbs_pkg::sbs_bus_s        rd_bus;
    sbs_pkg::sbs_bus_s        in_bus;

    // ************************************************************************
    // input qualification
    // ************************************************************************
    // strobe priority and chip-select decode
    always_comb begin
        proc_take = !proc_addr_strobe_n && !chip_sel_first_n;
        ctrl_take = !ctrl_addr_strobe_n && !proc_take;
        load      = proc_take || ctrl_take;
        cs_active = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
    end

    // lanes requested by the write inputs
    always_comb begin
        if (!all_bytes_write_n) begin
            wr_lanes_req = sbs_pkg::ALL_LANES;
        end else if (!byte_wr_enable_n) begin
            wr_lanes_req = ~byte_lane_select_n;
        end else begin
            wr_lanes_req = sbs_pkg::NO_LANES;
        end
    end

    assign in_bus.dq  = dq_in;
    assign in_bus.par = parity_lanes_in;

    // ************************************************************************
    // strap and sleep input
    // ************************************************************************
    // burst order follows the strap while in reset and is then frozen
    always_comb begin
        next_mode = nrst ? mode : burst_order_mode;
    end

    always_ff @(posedge core_clk) begin
        mode <= next_mode;
    end

    // sleep request is asynchronous: two-stage synchroniser
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sleep_meta <= 1'b0;
            sleep_sync <= 1'b0;
        end else begin
            sleep_meta <= sleep_request;
            sleep_sync <= sleep_meta;
        end
    end

    // ************************************************************************
    // access control and burst counter
    // ************************************************************************
    // decides selection, burst address and writes at each edge
    always_comb begin
        next_state      = state;
        next_addr_hi    = addr_hi;
        next_burst_base = burst_base;
        next_burst_step = burst_step;
        next_emerge     = 1'b0;
        next_wr_pend    = '0;
        next_wr_addr    = wr_addr;
        if (sleep_sync) begin
            next_state = sbs_pkg::SBS_SLEEP;
        end else if (load) begin
            next_addr_hi    = addr[ADDR_W-1:2];
            next_burst_base = addr[1:0];
            next_burst_step = sbs_pkg::BURST_STEP_ZERO;
            if (cs_active) begin
                next_emerge = (state == sbs_pkg::SBS_DESEL) ||
                              (state == sbs_pkg::SBS_SLEEP);
                // processor-started cycle ignores the write inputs
                if (ctrl_take && (wr_lanes_req != sbs_pkg::NO_LANES)) begin
                    next_state = sbs_pkg::SBS_WRITE;
                end else begin
                    next_state = sbs_pkg::SBS_READ;
                end
            end else begin
                next_state = sbs_pkg::SBS_DESEL;
            end
        end else if (state == sbs_pkg::SBS_SLEEP) begin
            next_state = sbs_pkg::SBS_DESEL;
        end else if (state != sbs_pkg::SBS_DESEL) begin
            // burst continuation: selects are not looked at here
            if (!burst_advance_n) begin
                next_burst_step = 2'(burst_step + sbs_pkg::BURST_STEP_ONE);
            end
            if (wr_lanes_req != sbs_pkg::NO_LANES) begin
                next_state = sbs_pkg::SBS_WRITE;
            end else begin
                next_state = sbs_pkg::SBS_READ;
            end
        end
        // write entry: capture lanes, data and the burst address now
        if (next_state == sbs_pkg::SBS_WRITE) begin
            next_wr_pend.lanes = wr_lanes_req;
            next_wr_pend.data  = sbs_pkg::to_lanes(in_bus);
            next_wr_addr       = {next_addr_hi,
                                  sbs_pkg::burst_low(next_burst_base, next_burst_step,
                                                     mode)};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state      <= sbs_pkg::SBS_DESEL;
            addr_hi    <= '0;
            burst_base <= sbs_pkg::BURST_STEP_ZERO;
            burst_step <= sbs_pkg::BURST_STEP_ZERO;
            emerge     <= 1'b0;
            wr_pend    <= '0;
            wr_addr    <= '0;
        end else begin
            state      <= next_state;
            addr_hi    <= next_addr_hi;
            burst_base <= next_burst_base;
            burst_step <= next_burst_step;
            emerge     <= next_emerge;
            wr_pend    <= next_wr_pend;
            wr_addr    <= next_wr_addr;
        end
    end

    // ************************************************************************
    // array
    // ************************************************************************
    // read address is the address that takes effect at this edge
    always_comb begin
        rd_addr = {next_addr_hi,
                   sbs_pkg::burst_low(next_burst_base, next_burst_step, mode)};
    end

    // pending write lands one edge later, behind the bus
    sbs_mem #(
        .ADDR_W (ADDR_W),
        .LANES  (sbs_pkg::LANES),
        .LANE_W (sbs_pkg::LANE_W)
    ) u_mem (
        .core_clk (core_clk),
        .nrst     (nrst),
        .wr_lanes (wr_pend.lanes),
        .wr_addr  (wr_addr),
        .wr_data  (wr_pend.data),
        .rd_addr  (rd_addr),
        .rd_data  (rd_word)
    );

    assign rd_bus           = sbs_pkg::from_lanes(rd_word);
    assign dq_out           = rd_bus.dq;
    assign parity_lanes_out = rd_bus.par;

    // ************************************************************************
    // output drive and status
    // ************************************************************************
    // drive only in a read that is not the first after deselect
    always_comb begin
        next_dq_oe_n = !((next_state == sbs_pkg::SBS_READ) && !out_enable_n &&
                         !next_emerge);
        next_sleep_active = (next_state == sbs_pkg::SBS_SLEEP);
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            dq_oe_n      <= 1'b1;
            sleep_active <= 1'b0;
        end else begin
            dq_oe_n      <= next_dq_oe_n;
            sleep_active <= next_sleep_active;
        end
    end

    // ************************************************************************
    // boundary-scan pin edges
    // ************************************************************************
    // one-bit scan path: sample on test clock rise, shift out on fall
    always_comb begin
        next_tck_q     = tck;
        next_scan_bit  = scan_bit;
        next_tms_count = tms_count;
        next_tdo       = tdo;
        if (tck && !tck_q) begin
            if (!tms) begin
                next_tms_count = 3'h0;
            end else if (tms_count != sbs_pkg::TAP_RESET_TMS_COUNT) begin
                next_tms_count = 3'(tms_count + 3'h1);
            end
            next_scan_bit = (next_tms_count == sbs_pkg::TAP_RESET_TMS_COUNT) ? 1'b0 :
                            tdi;
        end
        if (!tck && tck_q) begin
            next_tdo = scan_bit;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            tck_q     <= 1'b0;
            scan_bit  <= 1'b0;
            tms_count <= 3'h0;
            tdo       <= 1'b0;
        end else begin
            tck_q     <= next_tck_q;
            scan_bit  <= next_scan_bit;
            tms_count <= next_tms_count;
            tdo       <= next_tdo;
        end
    end

endmodule // sbs_port

// File: test/sbs_host_model.sv
// bus side of the host: resolves the shared data and parity wire
`timescale 1ns/1ps
module sbs_host_model (
    input  logic        core_clk,
    input  logic        host_drive,
    input  logic [35:0] host_bus,
    input  logic [31:0] dq_out,
    input  logic [3:0]  parity_lanes_out,
    input  logic        dq_oe_n,
    output logic [31:0] dq_in,
    output logic [3:0]  parity_lanes_in
);
    logic [35:0] last;
    logic [35:0] wire_lvl;
    // host drives write data only; host and device both driving gives x, a free bus keeps changing
    always_comb begin
        if (host_drive && !dq_oe_n) wire_lvl = 'x;
        else if (host_drive) wire_lvl = host_bus;
        else if (!dq_oe_n) wire_lvl = {parity_lanes_out, dq_out};
        else wire_lvl = ~last;
    end
    always_ff @(posedge core_clk) last <= wire_lvl;
    assign {parity_lanes_in, dq_in} = wire_lvl;
endmodule // sbs_host_model

// File: test/sbs_port_asserts.sv
// concurrent checks on the burst sram port pins
`timescale 1ns/1ps
module sbs_port_asserts #(
    parameter int ADDR_W = 20
) (
    input logic       core_clk,
    input logic       nrst,
    input logic       proc_addr_strobe_n,
    input logic       ctrl_addr_strobe_n,
    input logic       chip_sel_first_n,
    input logic       chip_sel_second,
    input logic       chip_sel_third_n,
    input logic       byte_wr_enable_n,
    input logic [3:0] byte_lane_select_n,
    input logic       all_bytes_write_n,
    input logic       out_enable_n,
    input logic       sleep_request,
    input logic       tck,
    input logic       dq_oe_n,
    input logic       sleep_active,
    input logic       tdo
);
    // ********
    // checks
    // ********
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // controller load with every select active
    wire sel_load = !ctrl_addr_strobe_n && proc_addr_strobe_n && !chip_sel_first_n
                    && chip_sel_second && !chip_sel_third_n;
    wire desel_load = !ctrl_addr_strobe_n && proc_addr_strobe_n && !chip_sel_second;

    a_oe_high_floats: assert property (out_enable_n |=> dq_oe_n)
        else $error("bus driven with output enable high");
    a_all_write_floats: assert property (!all_bytes_write_n && proc_addr_strobe_n |=> dq_oe_n)
        else $error("bus driven during all-lane write");
    a_byte_write_floats: assert property (!byte_wr_enable_n && byte_lane_select_n != 4'hf
                                          && proc_addr_strobe_n |=> dq_oe_n)
        else $error("bus driven during lane write");
    a_desel_floats: assert property (desel_load |=> dq_oe_n)
        else $error("bus driven after deselecting load");
    a_emerge_floats: assert property (desel_load ##1 sel_load |=> dq_oe_n)
        else $error("bus driven in first cycle after deselect");
    a_sleep_floats: assert property (sleep_active |-> dq_oe_n)
        else $error("bus driven while asleep");
    a_sleep_entry: assert property (sleep_request [*3] |=> sleep_active)
        else $error("sleep not entered two cycles after request");
    a_sleep_exit: assert property (!sleep_request [*3] |=> !sleep_active)
        else $error("sleep held after request dropped");
    a_scan_out_fall: assert property (!$stable(tdo) && $past(nrst) |-> !$past(tck) && $past(tck, 2))
        else $error("scan output changed away from a test clock fall");

    c_sleep: cover property (sleep_active);
    c_drive: cover property (!dq_oe_n);
    c_scan: cover property ($changed(tdo));
endmodule // sbs_port_asserts

bind sbs_port sbs_port_asserts #(.ADDR_W(ADDR_W)) chk_u (
    .core_clk(core_clk), .nrst(nrst), .proc_addr_strobe_n(proc_addr_strobe_n),
    .ctrl_addr_strobe_n(ctrl_addr_strobe_n), .chip_sel_first_n(chip_sel_first_n),
    .chip_sel_second(chip_sel_second), .chip_sel_third_n(chip_sel_third_n),
    .byte_wr_enable_n(byte_wr_enable_n), .byte_lane_select_n(byte_lane_select_n),
    .all_bytes_write_n(all_bytes_write_n), .out_enable_n(out_enable_n),
    .sleep_request(sleep_request), .tck(tck), .dq_oe_n(dq_oe_n),
    .sleep_active(sleep_active), .tdo(tdo));

// File: test/sbs_port_bench.sv
// self-checking bench for the burst sram port
`timescale 1ns/1ps
module sbs_port_bench;
    logic core_clk = 0, nrst = 0, tck = 0, tms = 0, tdi = 0, host_drive = 0;
    logic proc_addr_strobe_n = 1, ctrl_addr_strobe_n = 1, burst_advance_n = 1;
    logic chip_sel_first_n = 0, chip_sel_second = 1, chip_sel_third_n = 0;
    logic byte_wr_enable_n = 1, all_bytes_write_n = 1, out_enable_n = 1;
    logic sleep_request = 0, burst_order_mode = 0;
    logic [5:0]  addr = 6'h0;
    logic [3:0]  byte_lane_select_n = 4'hf, parity_lanes_in, parity_lanes_out;
    logic [31:0] dq_in, dq_out;
    logic [35:0] host_bus = 36'h0;
    logic [35:0] mdl [64];
    logic dq_oe_n, sleep_active, tdo;
    int num_errors = 0, comparisons = 0;

    always #4 core_clk = ~core_clk;
    sbs_port #(.ADDR_W(6)) dut_u (.core_clk(core_clk), .nrst(nrst), .addr(addr),
        .proc_addr_strobe_n(proc_addr_strobe_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
        .burst_advance_n(burst_advance_n), .chip_sel_first_n(chip_sel_first_n),
        .chip_sel_second(chip_sel_second), .chip_sel_third_n(chip_sel_third_n),
        .byte_wr_enable_n(byte_wr_enable_n), .byte_lane_select_n(byte_lane_select_n),
        .all_bytes_write_n(all_bytes_write_n), .out_enable_n(out_enable_n),
        .sleep_request(sleep_request), .burst_order_mode(burst_order_mode), .dq_in(dq_in),
        .parity_lanes_in(parity_lanes_in), .tck(tck), .tms(tms), .tdi(tdi), .dq_out(dq_out),
        .parity_lanes_out(parity_lanes_out), .dq_oe_n(dq_oe_n), .sleep_active(sleep_active),
        .tdo(tdo));
    sbs_host_model host_u (.core_clk(core_clk), .host_drive(host_drive), .host_bus(host_bus),
        .dq_out(dq_out), .parity_lanes_out(parity_lanes_out), .dq_oe_n(dq_oe_n),
        .dq_in(dq_in), .parity_lanes_in(parity_lanes_in));

    // ********
    // helpers
    // ********
    task automatic tick(); @(posedge core_clk); @(negedge core_clk); endtask
    task automatic finish_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check_word(input string n, input logic [35:0] e, input logic [35:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_bit(input string n, input logic e, input logic g);
        check_word(n, {35'h0, e}, {35'h0, g});
    endtask
    task automatic do_reset(input logic m);
        {nrst, burst_order_mode} = {1'b0, m};
        repeat (6) tick();
        nrst = 1;
    endtask
    // ********
    // scenarios
    // ********
    // back-to-back all-lane writes by controller strobe, lane selects left idle
    task automatic wr_blk(input logic [5:0] b);
        {ctrl_addr_strobe_n, all_bytes_write_n, host_drive, out_enable_n} = 4'h2;
        for (int i = 0; i < 4; i++) begin
            addr = b + 6'(i);
            host_bus = {4'h5 ^ 4'(i), 32'h0f1e2d3c + 32'h01010101 * 32'(i)};
            mdl[addr] = host_bus;
            tick();
            check_bit("oe_wr", 1'b1, dq_oe_n);
        end
        {ctrl_addr_strobe_n, all_bytes_write_n, host_drive} = 3'h6;
        tick();
    endtask
    task automatic rd_burst(input logic [5:0] a, input logic m);
        logic [1:0] lo;
        {addr, ctrl_addr_strobe_n, out_enable_n} = {a, 2'h0};
        tick();
        check_word("rd0", mdl[a], {parity_lanes_out, dq_out});
        {ctrl_addr_strobe_n, burst_advance_n, addr} = {2'h2, ~a};
        for (int s = 1; s < 4; s++) begin
            lo = m ? a[1:0] ^ 2'(s) : a[1:0] + 2'(s);
            tick();
            check_word("burst", mdl[{a[5:2], lo}], {parity_lanes_out, dq_out});
            check_bit("oe_rd", 1'b0, dq_oe_n);
        end
        burst_advance_n = 1;
    endtask
    // both strobes with write inputs, then a lane write and a non-enabled lane select
    task automatic wr_lanes();
        out_enable_n = 1;
        tick();
        {addr, proc_addr_strobe_n, ctrl_addr_strobe_n, all_bytes_write_n} = {6'h09, 3'h0};
        {host_drive, host_bus, out_enable_n} = {1'b1, 36'hfffffffff, 1'b1};
        tick();
        {proc_addr_strobe_n, ctrl_addr_strobe_n, all_bytes_write_n} = 3'h7;
        {byte_wr_enable_n, byte_lane_select_n, host_bus} = {5'h0a, 36'h5aabbccdd};
        tick();
        mdl[9] = {mdl[9][35], 1'b1, mdl[9][33], 1'b1, mdl[9][31:24], 8'hbb, mdl[9][15:8], 8'hdd};
        {byte_wr_enable_n, byte_lane_select_n, host_bus} = {5'h10, 36'h0};
        tick();
        {host_drive, byte_lane_select_n} = 5'h0f;
        rd_burst(6'h09, 1'b0);
    endtask
    // deselect, ignored strobes, reselect and hold
    task automatic desel();
        {ctrl_addr_strobe_n, chip_sel_second, out_enable_n} = 3'h0;
        tick();
        check_bit("oe_desel", 1'b1, dq_oe_n);
        {ctrl_addr_strobe_n, chip_sel_second, burst_advance_n} = 3'h6;
        tick();
        check_bit("oe_cont", 1'b1, dq_oe_n);
        {proc_addr_strobe_n, chip_sel_first_n, burst_advance_n} = 3'h3;
        tick();
        check_bit("oe_proc_ign", 1'b1, dq_oe_n);
        {proc_addr_strobe_n, chip_sel_first_n, ctrl_addr_strobe_n, addr} = {3'h4, 6'h0a};
        tick();
        check_bit("oe_emerge", 1'b1, dq_oe_n);
        check_word("rd_sel", mdl[10], {parity_lanes_out, dq_out});
        {ctrl_addr_strobe_n, addr} = {1'b1, 6'h0b};
        tick();
        check_word("hold", mdl[10], {parity_lanes_out, dq_out});
        check_bit("oe_hold", 1'b0, dq_oe_n);
        {proc_addr_strobe_n, chip_sel_first_n} = 2'h1;
        tick();
        check_word("proc_ign", mdl[10], {parity_lanes_out, dq_out});
        {proc_addr_strobe_n, chip_sel_first_n} = 2'h2;
    endtask
    // deselect, sleep, wake and read back
    task automatic sleep_cycle();
        int n;
        {ctrl_addr_strobe_n, chip_sel_second} = 2'h0;
        tick();
        {ctrl_addr_strobe_n, chip_sel_second, sleep_request} = 3'h7;
        n = 0;
        while (sleep_active !== 1'b1 && n < 8) begin
            tick();
            n++;
        end
        check_word("sleep_cycles", 36'h3, 36'(n));
        check_bit("oe_sleep", 1'b1, dq_oe_n);
        sleep_request = 0;
        for (n = 0; sleep_active !== 1'b0 && n < 8; n++) tick();
        if (n == 8) begin
            num_errors++;
            finish_test();
        end
        repeat (2) tick();
        rd_burst(6'h0a, 1'b0);
    endtask
    // scan bit sampled on test clock rise, shown after its fall
    task automatic scan();
        for (int i = 0; i < 4; i++) begin
            {tdi, tck} = {1'(i), 1'b1};
            repeat (4) tick();
            {tdi, tck} = {~1'(i), 1'b0};
            repeat (2) tick();
            check_bit("tdo", 1'(i), tdo);
        end
        // five mode-high rises clear the scan bit
        {tms, tdi} = 2'h3;
        for (int i = 0; i < 5; i++) begin
            tck = 1;
            repeat (2) tick();
            tck = 0;
            repeat (2) tick();
        end
        check_bit("tdo_tms", 1'b0, tdo);
    endtask

    initial begin
        do_reset(1'b0);
        wr_blk(6'h08);
        rd_burst(6'h09, 1'b0);
        wr_lanes();
        desel();
        sleep_cycle();
        scan();
        do_reset(1'b1);
        wr_blk(6'h08);
        rd_burst(6'h09, 1'b1);
        rd_burst(6'h0a, 1'b1);
        finish_test();
    end
endmodule // sbs_port_bench
